// ==== rtl/pw_defs.svh ====
`ifndef PW_DEFS_SVH
`define PW_DEFS_SVH
// data header: byte positions, flag bit and version
`define HDR_T_BIT 3'h7
`define HDR_VER_BYTE 4'h1
`define HDR_SID_BYTE 4'h4
`define HDR_LAST_BYTE 4'h7
`define L2TP_VERSION 4'h3
// sublayer header: byte positions and codes
`define SUB_FLAG_BYTE 4'h0
`define SUB_INFO_BYTE 4'h1
`define SUB_LAST_BYTE 4'h3
`define SUB_H_DATA 2'h0
`define MCM_MAX_PKTS 4'hA
// one mpeg segment is 188 bytes, counted 0 to 187
`define MPEG_LAST 8'hBB
// attribute records
`define ATTR_LEN 10'h008
`define ATTR_LATENCY 16'h0012
`define ATTR_SBFD 16'h0013
`define ATTR_MCAST 16'h0014
`define ATTR_SUBTYPE 16'h003F
`define ATTR_VENDOR 16'h0000
`define DROP_MAX 16'hFFFF
`endif

// ==== rtl/pw_pkg.sv ====
package pw_pkg;
  // parse states, gray along hdr -> sub -> pay
  typedef enum logic [1:0] {
    ST_HDR = 2'h0,
    ST_SUB = 2'h1,
    ST_PAY = 2'h3,
    ST_DROP = 2'h2
  } parse_state_e;
  // what one payload segment carries
  typedef enum logic [1:0] {
    K_MPEG = 2'h0,
    K_FRAME = 2'h1,
    K_FRAG = 2'h2,
    K_PLC = 2'h3
  } seg_kind_e;
  typedef struct packed {
    logic [7:0] data;
    logic last;
    seg_kind_e kind;
    logic [3:0] chan;
  } seg_word_s;
  typedef struct packed {
    logic known;
    logic down;
    logic mpt;
    logic multi;
  } sub_info_s;
  // sublayer subtype table; unlisted and reserved codes come back all zero
  function automatic sub_info_s decode_subtype(input logic [4:0] c);
    sub_info_s r;
    r = '0;
    case (c)
      5'h01, 5'h03, 5'h13: r = '{1'b1, 1'b1, 1'b1, 1'b0};
      5'h02, 5'h04, 5'h0D, 5'h0E, 5'h15, 5'h18: r = '{1'b1, 1'b1, 1'b0, 1'b0};
      5'h12, 5'h14: r = '{1'b1, 1'b0, 1'b1, 1'b0};
      5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C,
      5'h0F, 5'h10, 5'h16, 5'h17: r = '{1'b1, 1'b0, 1'b0, 1'b0};
      default: r = '0;
    endcase
    r.multi = (c == 5'h03);
    return r;
  endfunction
endpackage

// ==== rtl/seg_if.sv ====
`timescale 1ns/1ns
// segment word with valid/ready between parser and buffer
interface seg_if import pw_pkg::*; ();
  logic valid;
  logic ready;
  seg_word_s w;
  modport src(output valid, output w, input ready);
  modport snk(input valid, input w, output ready);
endinterface

// ==== rtl/seg_buffer.sv ====
`timescale 1ns/1ns
module seg_buffer import pw_pkg::*; (
  // clock, enable and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // filling side
  seg_if.snk in_s,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output seg_word_s out_w
);
  typedef struct packed {
    logic hv;
    logic sv;
    logic rdy;
    seg_word_s hd;
    seg_word_s sd;
  } buf_s;
  buf_s st;
  buf_s next_st;

  // head register drives the outputs; the spare entry catches a word during a stall
  always_comb begin
    next_st = st;
    if (st.hv && out_ready) begin
      if (st.sv) begin
        next_st.hd = st.sd;
        next_st.sv = 1'b0;
      end else begin
        next_st.hv = 1'b0;
      end
    end
    if (in_s.valid && !st.sv) begin
      if (!next_st.hv) begin
        next_st.hv = 1'b1;
        next_st.hd = in_s.w;
      end else begin
        next_st.sv = 1'b1;
        next_st.sd = in_s.w;
      end
    end
    // room for the next cycle is registered with the rest of the state
    next_st.rdy = !next_st.sv;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.rdy <= 1'b1;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ready is a flop: no combinational path from out_ready back to the source
  assign in_s.ready = st.rdy;
  assign out_valid = st.hv;
  assign out_w = st.hd;
endmodule // seg_buffer

// ==== rtl/attr_codec.sv ====
`timescale 1ns/1ns
`include "pw_defs.svh"
module attr_codec import pw_pkg::*; (
  // clock, enable and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // incoming setup record
  input wire logic rec_valid,
  input wire logic [63:0] rec_data,
  // decoded values
  output logic [15:0] latency_phb,
  output logic [15:0] sbfd_phb,
  output logic [15:0] mcast_port,
  output logic mcast_port_valid,
  output logic rec_err,
  output logic [4:0] subtype,
  output sub_info_s info,
  output logic [63:0] reply_record
);
  typedef struct packed {
    logic [15:0] lat;
    logic [15:0] sbfd;
    logic [15:0] mport;
    logic mvalid;
    logic err;
    logic [4:0] sub;
    sub_info_s info;
    logic [63:0] reply;
  } codec_s;
  codec_s st;
  codec_s next_st;
  logic hdr_ok;
  logic [15:0] typ;
  logic [15:0] val;
  sub_info_s cand;

  // record layout: m, 5 spare bits, length, vendor, type, value
  assign hdr_ok = rec_data[63] && (rec_data[57:48] == `ATTR_LEN);
  assign typ = rec_data[31:16];
  assign val = rec_data[15:0];
  assign cand = decode_subtype(val[4:0]);

  always_comb begin
    next_st = st;
    next_st.err = 1'b0;
    if (rec_valid) begin
      if (!hdr_ok) begin
        next_st.err = 1'b1;
      end else if (typ == `ATTR_LATENCY) begin
        next_st.lat = val;
      end else if (typ == `ATTR_SBFD) begin
        next_st.sbfd = val;
      end else if (typ == `ATTR_MCAST) begin
        next_st.mport = val;
        next_st.mvalid = 1'b1;
      end else if (typ == `ATTR_SUBTYPE && val[15:5] == 11'h000 && cand.known) begin
        next_st.sub = val[4:0];
        next_st.info = cand;
      end else begin
        next_st.err = 1'b1; // reserved or unknown codes are refused
      end
    end
    // reply carries the session's own subtype back
    next_st.reply = {1'b1, 5'h00, `ATTR_LEN, `ATTR_VENDOR, `ATTR_SUBTYPE, 11'h000, next_st.sub};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // the reply word is a well-formed record even before any subtype is taken
      st <= '0;
      st.reply <= {1'b1, 5'h00, `ATTR_LEN, `ATTR_VENDOR, `ATTR_SUBTYPE, 16'h0000};
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign latency_phb = st.lat;
  assign sbfd_phb = st.sbfd;
  assign mcast_port = st.mport;
  assign mcast_port_valid = st.mvalid;
  assign rec_err = st.err;
  assign subtype = st.sub;
  assign info = st.info;
  assign reply_record = st.reply;
endmodule // attr_codec

// ==== rtl/pseudowire_data_header_codec.sv ====
`timescale 1ns/1ns
`include "pw_defs.svh"
module pseudowire_data_header_codec import pw_pkg::*; (
  // clock, enable and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // packet bytes from the headend core
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_last,
  output logic in_ready,
  // payload segments out
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data,
  output logic out_last,
  output logic [1:0] out_kind,
  output logic [3:0] out_chan,
  // session setup
  input wire logic [31:0] session_id,
  input wire logic session_up,
  // session supervision
  output logic teardown_req,
  input wire logic teardown_ack,
  output logic [15:0] drop_count,
  // setup records
  input wire logic rec_valid,
  input wire logic [63:0] rec_data,
  output logic rec_err,
  output logic [4:0] session_subtype,
  output logic [15:0] latency_phb,
  output logic [15:0] sbfd_phb,
  output logic [15:0] mcast_port,
  output logic mcast_port_valid,
  output logic [63:0] reply_record
);
  typedef struct packed {
    parse_state_e st;
    logic [3:0] hcnt;
    logic [7:0] scnt;
    logic [3:0] sidx;
    logic [31:0] sid;
    logic bad;
    logic [1:0] h;
    seg_kind_e kind;
    logic [3:0] pcnt;
    logic tear;
    logic [15:0] drops;
  } parse_s;
  // packet as it arrives, one byte a cycle:
  //   bytes 0-7   data header; byte 0 bit 7 is the transport flag,
  //               byte 1 low nibble the version, bytes 4-7 the session
  //               identifier, most significant byte first
  //   bytes 8-11  sublayer header; byte 8 bits 5:4 select the header kind,
  //               byte 9 holds the segment count (low nibble) and the
  //               streaming kind (top two bits)
  //   bytes 12 on payload, forwarded one byte per buffer word
  // hcnt counts bytes inside a header, scnt bytes inside an mpeg segment,
  // sidx segments inside a packet; pcnt keeps the announced count so the
  // end of the packet can be held against it
  // a reset in mid-packet loses the half-parsed packet, by design

  parse_s s;
  parse_s next_s;
  logic [1:0] rsync;
  logic rst_n;
  sub_info_s info;
  seg_word_s buf_w;
  logic take;
  logic sess_ok;
  logic seg_end;
  logic [31:0] sid_full;

  // parser to buffer handshake
  seg_if seg ();

  // reset release passes two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rsync <= 2'h0;
    end else begin
      rsync <= {rsync[0], 1'b1};
    end
  end
  assign rst_n = rsync[1];

  // setup record decode and reply build
  // the codec holds the accepted subtype that every packet is judged against
  attr_codec u_codec (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .rec_valid(rec_valid),
    .rec_data(rec_data),
    .latency_phb(latency_phb),
    .sbfd_phb(sbfd_phb),
    .mcast_port(mcast_port),
    .mcast_port_valid(mcast_port_valid),
    .rec_err(rec_err),
    .subtype(session_subtype),
    .info(info),
    .reply_record(reply_record)
  );

  // two-entry buffer so a stalled receiver loses no byte
  seg_buffer u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_s(seg.snk),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_w(buf_w)
  );

  // the buffer head is unpacked onto the pins; every field is a flop bit
  assign out_data = buf_w.data;
  assign out_last = buf_w.last;
  assign out_kind = buf_w.kind;
  assign out_chan = buf_w.chan;

  // ce low freezes parser and buffer together, but in_ready is not gated by ce, so
  // a byte handed over while ce is low is never taken and is lost
  // header bytes also wait for buffer room; one handshake for every phase keeps it simple
  assign in_ready = seg.ready;
  assign take = in_valid && seg.ready;
  // only a downstream session with a known subtype counts as set up
  assign sess_ok = session_up && info.known && info.down;
  // the count before this byte is looked at, so seg_end is true on the 188th byte
  assign seg_end = (s.scnt == `MPEG_LAST);
  // identifier as it stands once this byte is shifted in; judging it on byte 7
  // saves a cycle over judging the register afterwards
  assign sid_full = {s.sid[23:0], in_data};

  // byte-serial parser: data header, sublayer header, payload, or drop to packet end
  always_comb begin
    next_s = s;
    seg.valid = 1'b0;
    seg.w = '0;
    // acknowledge clears the flag; a new mismatch below wins
    if (teardown_ack) begin
      next_s.tear = 1'b0;
    end
    // payload goes to the buffer straight from the pin; in_ready already
    // tells the source whether the buffer has room
    if (s.st == ST_PAY) begin
      seg.valid = in_valid;
      seg.w.data = in_data;
      seg.w.kind = s.kind;
      seg.w.chan = info.multi ? s.sidx : 4'h0;
      if (info.mpt) begin
        seg.w.last = seg_end || in_last;
      end else begin
        seg.w.last = in_last;
      end
    end
    // everything below moves only on a byte actually taken
    if (take) begin
      case (s.st)
        ST_HDR: begin
          next_s.hcnt = s.hcnt + 4'h1;
          if (s.hcnt == 4'h0) begin
            next_s.bad = in_data[`HDR_T_BIT];
          end
          // the reserved bits around version and the second reserved field are ignored
          if (s.hcnt == `HDR_VER_BYTE && in_data[3:0] != `L2TP_VERSION) begin
            next_s.bad = 1'b1;
          end
          // identifier bytes shift in at the bottom and move up, most significant first
          if (s.hcnt >= `HDR_SID_BYTE) begin
            next_s.sid = sid_full;
          end
          if (in_last) begin
            // runt packet, nothing to forward
            next_s.hcnt = 4'h0;
          end else if (s.hcnt == `HDR_LAST_BYTE) begin
            // no cookie: sublayer header starts next
            next_s.hcnt = 4'h0;
            if (s.bad) begin
              next_s.st = ST_DROP;
            end else if (!sess_ok || sid_full != session_id) begin
              next_s.st = ST_DROP;
              // the count stops at its top value rather than wrap to zero
              if (s.drops != `DROP_MAX) begin
                next_s.drops = s.drops + 16'h0001;
              end
            end else begin
              next_s.st = ST_SUB;
            end
          end
        end
        ST_SUB: begin
          next_s.hcnt = s.hcnt + 4'h1;
          // flag byte keeps the header kind; the info byte keeps count and kind
          if (s.hcnt == `SUB_FLAG_BYTE) begin
            next_s.h = in_data[5:4];
          end
          if (s.hcnt == `SUB_INFO_BYTE) begin
            next_s.pcnt = in_data[3:0];
            if (info.mpt) begin
              next_s.kind = K_MPEG;
            end else begin
              // streaming: top two bits pick frame, fragment or link channel
              case (in_data[7:6])
                2'h0: next_s.kind = K_FRAME;
                2'h1: next_s.kind = K_FRAG;
                2'h2: next_s.kind = K_PLC;
                default: next_s.bad = 1'b1;
              endcase
            end
          end
          if (in_last) begin
            next_s.st = ST_HDR;
            next_s.hcnt = 4'h0;
          end else if (s.hcnt == `SUB_LAST_BYTE) begin
            next_s.hcnt = 4'h0;
            next_s.scnt = 8'h00;
            next_s.sidx = 4'h0;
            if (s.h != `SUB_H_DATA || s.bad) begin
              // latency and undefined headers are not payload; dropped quietly
              next_s.st = ST_DROP;
            end else if (info.multi && (s.pcnt == 4'h0 || s.pcnt > `MCM_MAX_PKTS)) begin
              next_s.st = ST_DROP;
            end else begin
              next_s.st = ST_PAY;
            end
          end
        end
        ST_PAY: begin
          if (info.mpt) begin
            next_s.scnt = seg_end ? 8'h00 : s.scnt + 8'h01;
            if (seg_end) begin
              next_s.sidx = s.sidx + 4'h1;
            end
          end
          if (in_last) begin
            next_s.st = ST_HDR;
            next_s.hcnt = 4'h0;
            // a partial mpeg segment or a count mismatch means a foreign format
            if (info.mpt && !seg_end) begin
              next_s.tear = 1'b1;
            end
            if (info.multi && seg_end && (s.sidx + 4'h1) != s.pcnt) begin
              next_s.tear = 1'b1;
            end
          end
        end
        // dropped packets still wait on in_ready like every phase, so a stalled receiver
        // can hold up a bad packet and the one behind it
        ST_DROP: begin
          if (in_last) begin
            next_s.st = ST_HDR;
            next_s.hcnt = 4'h0;
          end
        end
        // no encoding is left unused; an unknown state value falls back to waiting for a header
        default: begin
          next_s.st = ST_HDR;
        end
      endcase
    end
  end

  // the parser uses the synchronised reset copy, so its release is clean
  // against the clock even when rstn rises close to an edge
  // all parser state in one register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // supervision outputs are plain register copies
  assign teardown_req = s.tear;
  assign drop_count = s.drops;
endmodule // pseudowire_data_header_codec

// ==== dv/pw_chk.sv ====
`timescale 1ns/1ns
module pw_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // segment stream
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic [1:0] out_kind,
  // supervision and records
  input wire logic teardown_req,
  input wire logic teardown_ack,
  input wire logic rec_valid,
  input wire logic [63:0] rec_data,
  input wire logic rec_err,
  input wire logic [4:0] session_subtype,
  input wire logic [15:0] latency_phb,
  input wire logic [15:0] mcast_port,
  input wire logic mcast_port_valid,
  input wire logic [63:0] reply_record
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // well-formed record header of one type
  sequence rec_hit(t);
    rec_valid && rec_data[63:32] == 32'h8008_0000 && rec_data[31:16] == t;
  endsequence
  // a stalled word must not move, or the receiver loses it
  chk_stream_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable({out_data, out_last, out_kind})) else $error("stalled word changed");
  chk_m_refused: assert property (rec_valid && !rec_data[63] |=> rec_err)
    else $error("record without mandatory bit taken");
  chk_len_refused: assert property (rec_valid && rec_data[57:48] != 10'h008 |=> rec_err)
    else $error("record with bad length taken");
  chk_latency_load: assert property (rec_hit(16'h0012) |=>
    latency_phb == $past(rec_data[15:0]) && !rec_err) else $error("latency code not loaded");
  chk_mcast_load: assert property (rec_hit(16'h0014) |=>
    mcast_port == $past(rec_data[15:0]) && mcast_port_valid) else $error("port not loaded");
  chk_reserved_sub: assert property ((rec_hit(16'h003F) ##0
    rec_data[15:0] inside {16'h0005, 16'h0011}) |=> rec_err && $stable(session_subtype))
    else $error("reserved subtype taken");
  chk_reply_form: assert property (reply_record ==
    {16'h8008, 16'h0000, 16'h003F, 11'h000, session_subtype}) else $error("reply record wrong");
  chk_teardown_held: assert property (teardown_req && !teardown_ack |=> teardown_req)
    else $error("teardown request lost");
  chk_mpeg_kind: assert property (out_valid && session_subtype inside {5'h01, 5'h03, 5'h13}
    |-> out_kind == 2'h0) else $error("mpeg segment with other kind");
endmodule // pw_chk

bind pseudowire_data_header_codec pw_chk u_chk (.clk(clk), .rstn(rstn), .out_valid(out_valid),
  .out_ready(out_ready), .out_data(out_data), .out_last(out_last), .out_kind(out_kind),
  .teardown_req(teardown_req), .teardown_ack(teardown_ack), .rec_valid(rec_valid),
  .rec_data(rec_data), .rec_err(rec_err), .session_subtype(session_subtype),
  .latency_phb(latency_phb), .mcast_port(mcast_port), .mcast_port_valid(mcast_port_valid),
  .reply_record(reply_record));

// ==== dv/core_model.sv ====
`timescale 1ns/1ns
module core_model (
  // clock
  input wire logic clk,
  // byte stream to the node
  input wire logic in_ready,
  output logic in_valid,
  output logic [7:0] in_data,
  output logic in_last,
  // setup records
  output logic rec_valid,
  output logic [63:0] rec_data
);
  // idle lines at time zero
  initial begin
    in_valid = 1'b0;
    in_data = 8'h00;
    in_last = 1'b0;
    rec_valid = 1'b0;
    rec_data = 64'h0;
  end
  // one byte, held until the node takes it
  task automatic put(input logic [7:0] d, input logic l);
    in_valid <= 1'b1;
    in_data <= d;
    in_last <= l;
    @(posedge clk);
    while (in_ready !== 1'b1) @(posedge clk);
  endtask
  // byte 0 from the caller, other reserved fields zero, version 3, no cookie, sublayer of the session type
  task automatic pkt(input logic [7:0] b0, input logic [31:0] sid, input logic [7:0] b9, input int n);
    logic [95:0] h;
    h = {b0, 8'h03, 16'h0000, sid, 8'h00, b9, 16'h0000};
    for (int i = 0; i < 12; i++)
      put(h[95 - 8 * i -: 8], 1'b0);
    for (int i = 0; i < n; i++)
      put(i[7:0], i == n - 1);
    in_valid <= 1'b0;
    in_last <= 1'b0;
    in_data <= ~in_data;
  endtask
  // one setup record for a single edge; the word is scrambled afterwards
  task automatic rec(input logic [63:0] w);
    rec_valid <= 1'b1;
    rec_data <= w;
    @(posedge clk);
    rec_valid <= 1'b0;
    rec_data <= ~w;
  endtask
endmodule // core_model

// ==== dv/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  // design ports
  logic clk, rstn, ce, in_valid, in_last, in_ready, out_valid, out_ready, out_last;
  logic session_up, teardown_req, teardown_ack, rec_valid, rec_err, mcast_port_valid;
  logic [7:0] in_data, out_data;
  logic [1:0] out_kind, cyc = 2'h0;
  logic [3:0] out_chan;
  logic [4:0] session_subtype;
  logic [31:0] session_id;
  logic [15:0] drop_count, latency_phb, sbfd_phb, mcast_port, exp_drop;
  logic [63:0] rec_data, reply_record;
  logic [14:0] q[$];
  logic [1:0] kd[3];
  logic stall;
  int bad_count, checked;
  pseudowire_data_header_codec u_dut (.clk(clk), .rstn(rstn), .ce(ce), .in_valid(in_valid),
    .in_data(in_data), .in_last(in_last), .in_ready(in_ready), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_last(out_last), .out_kind(out_kind),
    .out_chan(out_chan), .session_id(session_id), .session_up(session_up),
    .teardown_req(teardown_req), .teardown_ack(teardown_ack), .drop_count(drop_count),
    .rec_valid(rec_valid), .rec_data(rec_data), .rec_err(rec_err),
    .session_subtype(session_subtype), .latency_phb(latency_phb), .sbfd_phb(sbfd_phb),
    .mcast_port(mcast_port), .mcast_port_valid(mcast_port_valid), .reply_record(reply_record));
  core_model u_core (.clk(clk), .in_ready(in_ready), .in_valid(in_valid), .in_data(in_data),
    .in_last(in_last), .rec_valid(rec_valid), .rec_data(rec_data));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // receiver stalls one cycle in four, and fully while stall is set
  always @(posedge clk) begin
    cyc <= cyc + 2'h1;
    out_ready <= !stall && cyc != 2'h3;
    if (out_valid === 1'b1 && out_ready === 1'b1) q.push_back({out_last, out_kind, out_chan, out_data});
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [63:0] rw(input logic [15:0] t, input logic [15:0] v);
    return {16'h8008, 16'h0000, t, v};
  endfunction
  task automatic sp(input logic [63:0] w);
    @(posedge clk);
    u_core.rec(w);
    @(negedge clk);
  endtask
  // one packet, then wait for the buffer to drain
  task automatic run(input logic [7:0] b0, input logic [31:0] sid, input logic [7:0] b9, input int n);
    @(posedge clk);
    q.delete();
    u_core.pkt(b0, sid, b9, n);
    @(posedge clk);
    for (int k = 0; k < 40 && out_valid !== 1'b0; k++) @(posedge clk);
    @(negedge clk);
  endtask
  // kind is left out: it is judged per mode elsewhere
  task automatic seg(input int n, input logic mc);
    chk(q.size(), n);
    for (int i = 0; i < n; i++)
      chk({q[i][14], q[i][11:0]}, {i % 188 == 187 || i == n - 1, mc ? 4'(i / 188) : 4'h0, i[7:0]});
  endtask
  task automatic drp(input logic [7:0] b0, input logic [31:0] sid, input logic [7:0] b9, input int inc);
    run(b0, sid, b9, 5);
    exp_drop += inc;
    chk(q.size(), 0);
    chk(drop_count, exp_drop);
  endtask
  task automatic t_rec;
    logic [4:0] cur;
    logic ok;
    cur = 5'h00;
    chk({in_ready, drop_count}, 17'h10000);
    for (int c = 0; c < 26; c++) begin
      ok = c > 0 && c < 25 && c != 5 && c != 17;
      if (ok) cur = c[4:0];
      sp(rw(16'h003F, c[15:0]));
      chk(rec_err, !ok);
      chk(reply_record, rw(16'h003F, {11'h000, cur}));
    end
    sp(rw(16'h0012, 16'h00B8));
    sp(rw(16'h0013, 16'h0028));
    sp(rw(16'h0014, 16'h1F90));
    chk({latency_phb, sbfd_phb, mcast_port_valid, mcast_port}, {32'h00B80028, 17'h11F90});
    sp(rw(16'h0014, 16'h0050) & ~(64'h1 << 63));
    chk({rec_err, mcast_port}, 17'h11F90);
    sp(rw(16'h0012, 16'h0001) ^ (64'h1 << 48));
    chk({rec_err, latency_phb}, 17'h100B8);
    $display("t_rec done");
  endtask
  task automatic t_mpeg;
    sp(rw(16'h003F, 16'h0001));
    stall <= 1'b1;
    fork
      run(8'h7F, session_id, 8'h00, 376);
      begin
        repeat (30) @(negedge clk);
        chk(in_ready, 1'b0);
        stall <= 1'b0;
      end
    join
    seg(376, 1'b0);
    chk({teardown_req, drop_count}, {1'b0, exp_drop});
    $display("t_mpeg done");
  endtask
  task automatic t_mcm;
    sp(rw(16'h003F, 16'h0003));
    run(8'h00, session_id, 8'h02, 376);
    seg(376, 1'b1);
    chk(teardown_req, 1'b0);
    run(8'h00, session_id, 8'h03, 376);
    chk(teardown_req, 1'b1);
    @(posedge clk);
    teardown_ack <= 1'b1;
    @(posedge clk);
    teardown_ack <= 1'b0;
    @(negedge clk);
    chk(teardown_req, 1'b0);
    $display("t_mcm done");
  endtask
  task automatic t_psp;
    sp(rw(16'h003F, 16'h0002));
    for (int k = 0; k < 3; k++) begin
      run(8'h00, session_id, 8'(k << 6), 5);
      seg(5, 1'b0);
      kd[k] = q[0][13:12];
    end
    chk(kd[0] != kd[1] && kd[1] != kd[2] && kd[0] != kd[2] && kd[0] && kd[1] && kd[2], 1'b1);
    drp(8'h00, session_id, 8'hC0, 0);
    $display("t_psp done");
  endtask
  task automatic t_drop;
    sp(rw(16'h003F, 16'h0001));
    drp(8'h80, session_id, 8'h00, 0);
    drp(8'h00, ~session_id, 8'h00, 1);
    @(posedge clk);
    session_up <= 1'b0;
    drp(8'h00, session_id, 8'h00, 1);
    @(posedge clk);
    session_up <= 1'b1;
    sp(rw(16'h003F, 16'h0003));
    drp(8'h00, session_id, 8'h0B, 0);
    sp(rw(16'h003F, 16'h0006));
    drp(8'h00, session_id, 8'h00, 1);
    $display("t_drop done");
  endtask
  task automatic end_sim;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // a hang far beyond the few thousand cycles of the tests
  initial begin
    #300000;
    bad_count++;
    end_sim();
  end
  initial begin
    {rstn, teardown_ack, stall} = 3'h0;
    {ce, session_up} = 2'h3;
    session_id = 32'hA5C30F01;
    exp_drop = 16'h0000;
    bad_count = 0;
    checked = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_rec();
    t_mpeg();
    t_mcm();
    t_psp();
    t_drop();
    end_sim();
  end
endmodule // tb_top
